/* design/modbus_param_io_access.sv */
// Slave command handler: register writes, exception answers, comm DI/DO.
// Assumes framer on the same clock; parameter attributes answer same cycle.
`timescale 1ns/100ps

module modbus_param_io_access #(
	parameter int TICK_CYCLES = mpio_pkg::TICK_CYCLES_DEFAULT,
	parameter logic [15:0] UNLOCK_MS = mpio_pkg::UNLOCK_MS_DEFAULT,
	parameter logic [7:0] MAX_GROUP = 8'h0F,
	parameter logic [15:0] PASSWORD_ADDR = 16'h0000
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] stationAddress,
	input mpio_pkg::rx_byte_t rx,
	output logic txValid,
	output logic [7:0] txByte,
	output logic txLast,
	input wire logic txReady,
	output logic [15:0] lookupAddr,
	input wire logic attrExists,
	input wire logic attrWide,
	input wire logic attrUpper,
	input wire logic attrEditable,
	input wire logic [31:0] attrMin,
	input wire logic [31:0] attrMax,
	input wire logic [31:0] paramReadData,
	output mpio_pkg::param_write_t paramWrite,
	input wire logic protectionActive,
	input wire logic [15:0] userPassword,
	input wire logic [63:0] commInputEnableMask,
	input wire logic [63:0] physicalInputAssigned,
	input wire logic [15:0] commRefreshTimeoutSetting,
	output logic [63:0] commInputFunctions,
	output logic faultResetPulse,
	output logic positionErrorClearFunction,
	output logic inputConflictFault,
	input wire logic [31:0] outputFunctionActive,
	input wire logic [31:0] commOutputEnableMask,
	input wire logic [31:0] physicalOutputAssigned,
	input wire logic [31:0] encoderTurns,
	input wire logic [31:0] encoderSingleTurn
);
	mpio_pkg::state_t s_q, s_d;
	logic [7:0] func;
	logic [15:0] rawStart, startAddr, qtyField, qtyEff, regAddr, w0, w1;
	logic [15:0] outA, outB;
	logic nonVolatile, tick, refreshExpire, selWrite;
	logic isOwn, isOutA, isEnc, isEncLow, isEncHigh, isPass, isExt;
	logic wideLow, upper, isWrite, outRange;
	logic [31:0] rd32, value32;
	logic [7:0] frameCause, regCause;
	logic frameDrop;
	logic [5:0] step, txPos;

	function automatic logic [15:0] frameWord(
		input logic [mpio_pkg::FRAME_MAX-1:0][7:0] b,
		input logic [5:0] idx
	);
		logic [6:0] hi;
		hi = {idx, 1'b0} + 7'h07;
		if (b[1] == mpio_pkg::FN_WRITE_ONE)
			frameWord = {b[4], b[5]};
		else if (hi < 7'(mpio_pkg::FRAME_MAX - 1))
			frameWord = {b[hi[5:0]], b[hi[5:0] + 6'h01]};
		else
			frameWord = 16'h0000;
	endfunction

	assign outA = outputFunctionActive[15:0] & commOutputEnableMask[15:0]
		& ~physicalOutputAssigned[15:0] & mpio_pkg::OUT_A_MASK;
	assign outB = outputFunctionActive[31:16] & commOutputEnableMask[31:16]
		& ~physicalOutputAssigned[31:16];
	assign commInputFunctions = {16'h0000, s_q.sel[2] & mpio_pkg::SEL_C_MASK,
		s_q.sel[1], s_q.sel[0] & mpio_pkg::SEL_A_MASK}
		& commInputEnableMask;
	assign txValid = s_q.phase == mpio_pkg::phSend;
	assign txByte = s_q.txBuf[s_q.txIdx];
	assign txLast = txValid && (s_q.txIdx == s_q.txLen - 6'h01);
	assign lookupAddr = regAddr;
	assign paramWrite = s_q.pw;
	assign faultResetPulse = s_q.faultReset;
	assign positionErrorClearFunction = s_q.posClear;
	assign inputConflictFault = s_q.conflict;

	always_comb
	begin
		s_d = s_q;
		s_d.pw.strobe = 1'b0;
		s_d.faultReset = 1'b0;
		s_d.posClear = 1'b0;
		s_d.conflict = |(commInputFunctions & physicalInputAssigned);
		func = s_q.rxBuf[1];
		rawStart = {s_q.rxBuf[2], s_q.rxBuf[3]};
		nonVolatile = rawStart >= mpio_pkg::NV_OFFSET;
		startAddr = nonVolatile ? rawStart - mpio_pkg::NV_OFFSET : rawStart;
		qtyField = {s_q.rxBuf[4], s_q.rxBuf[5]};
		qtyEff = (func == mpio_pkg::FN_WRITE_ONE) ? 16'h0001 : qtyField;
		regAddr = startAddr + {10'h000, s_q.pos};
		w0 = frameWord(s_q.rxBuf, s_q.pos);
		w1 = frameWord(s_q.rxBuf, s_q.pos + 6'h01);
		isWrite = func != mpio_pkg::FN_READ;
		isOwn = regAddr >= mpio_pkg::ADDR_SEL_A && regAddr <= mpio_pkg::ADDR_SEL_D;
		isOutA = regAddr == mpio_pkg::ADDR_OUT_A;
		isEncLow = regAddr == mpio_pkg::ADDR_TURNS
			|| regAddr == mpio_pkg::ADDR_SINGLE;
		isEncHigh = regAddr == mpio_pkg::ADDR_TURNS + 16'h0001
			|| regAddr == mpio_pkg::ADDR_SINGLE + 16'h0001;
		isEnc = isEncLow || isEncHigh;
		isPass = regAddr == PASSWORD_ADDR;
		isExt = !isOwn && !isOutA && !isEnc && !isPass;
		wideLow = isEncLow || (isExt && attrWide);
		upper = isEncHigh || (isExt && attrUpper);
		step = wideLow ? 6'h02 : 6'h01;
		value32 = wideLow ? {w1, w0} : {16'h0000, w0};
		outRange = $signed(value32) < $signed(attrMin)
			|| $signed(value32) > $signed(attrMax);
		// Read value of the register under the cursor
		if (regAddr[15:1] == mpio_pkg::ADDR_TURNS[15:1])
			rd32 = encoderTurns;
		else if (regAddr[15:1] == mpio_pkg::ADDR_SINGLE[15:1])
			rd32 = encoderSingleTurn;
		else if (isOutA)
			rd32 = {16'h0000, outA};
		else if (regAddr == mpio_pkg::ADDR_OUT_B)
			rd32 = {16'h0000, outB};
		else if (regAddr == mpio_pkg::ADDR_SEL_A)
			rd32 = {16'h0000, s_q.sel[0]};
		else if (regAddr == mpio_pkg::ADDR_SEL_B)
			rd32 = {16'h0000, s_q.sel[1]};
		else if (isExt)
			rd32 = paramReadData;
		else
			rd32 = 32'h00000000;
		// Per-register check, in priority order
		regCause = mpio_pkg::CAUSE_NONE;
		if (isExt && regAddr[15:8] > MAX_GROUP)
			regCause = mpio_pkg::CAUSE_GROUP;
		else if (isExt && !attrExists)
			regCause = mpio_pkg::CAUSE_BAD_PARAM;
		else if (isExt && protectionActive && !s_q.unlocked)
			regCause = mpio_pkg::CAUSE_LOCKED;
		else if (upper || (wideLow && {10'h000, s_q.pos} + 16'h0001 >= qtyEff))
			regCause = mpio_pkg::CAUSE_HALF;
		else if (isWrite && isPass && qtyEff != 16'h0001)
			regCause = mpio_pkg::CAUSE_PASSWORD_MIX;
		else if (isWrite && isPass && w0 != userPassword)
			regCause = (s_q.wrongCnt >= mpio_pkg::WRONG_LIMIT - 3'h1)
				? mpio_pkg::CAUSE_WRONG_FIVE
				: mpio_pkg::CAUSE_WRONG_PASSWORD;
		else if (isWrite && (isOutA || isEnc || (isExt && !attrEditable)))
			regCause = mpio_pkg::CAUSE_NOT_EDITABLE;
		else if (isWrite && isExt && outRange)
			regCause = mpio_pkg::CAUSE_RANGE;
		// Frame-level check
		frameDrop = s_q.over || s_q.count < 6'h02
			|| (s_q.rxBuf[0] != stationAddress && s_q.rxBuf[0] != 8'h00);
		frameCause = mpio_pkg::CAUSE_NONE;
		if (!s_q.crcOk)
			frameCause = mpio_pkg::CAUSE_CRC;
		else if (func != mpio_pkg::FN_READ && func != mpio_pkg::FN_WRITE_ONE
			&& func != mpio_pkg::FN_WRITE_MULTI)
			frameCause = mpio_pkg::CAUSE_BAD_CMD;
		else if (func != mpio_pkg::FN_WRITE_MULTI && s_q.count != 6'h06)
			frameCause = mpio_pkg::CAUSE_BAD_PARAM;
		else if (func != mpio_pkg::FN_WRITE_ONE && qtyField == 16'h0000)
			frameCause = mpio_pkg::CAUSE_QTY_ZERO;
		else if (func == mpio_pkg::FN_READ && qtyField > 16'(mpio_pkg::READ_MAX))
			frameCause = mpio_pkg::CAUSE_BAD_PARAM;
		else if (func == mpio_pkg::FN_WRITE_MULTI
			&& (qtyField > 16'(mpio_pkg::WRITE_MAX)
			|| {1'b0, s_q.rxBuf[6]} != {qtyField[7:0], 1'b0}
			|| {3'h0, s_q.count} != {1'b0, s_q.rxBuf[6]} + 9'h007))
			frameCause = mpio_pkg::CAUSE_BAD_PARAM;
		// Millisecond timers
		tick = s_q.prescale == 32'(TICK_CYCLES - 1);
		s_d.prescale = tick ? 32'h00000000 : s_q.prescale + 32'h00000001;
		refreshExpire = tick && s_q.refreshMs >= commRefreshTimeoutSetting;
		if (refreshExpire)
			s_d.sel[0][mpio_pkg::BIT_SERVO_ON] = 1'b0;
		else if (tick && s_q.refreshMs != 16'hFFFF)
			s_d.refreshMs = s_q.refreshMs + 16'h0001;
		if (tick && s_q.unlocked)
		begin
			s_d.unlockMs = s_q.unlockMs + 16'h0001;
			if (s_q.unlockMs >= UNLOCK_MS)
				s_d.unlocked = 1'b0;
		end
		selWrite = 1'b0;
		txPos = {s_q.pos[4:0], 1'b0} + 6'h03;
		case (s_q.phase)
			mpio_pkg::phIdle:
			begin
				if (rx.valid)
				begin
					if (s_q.count < 6'(mpio_pkg::FRAME_MAX))
					begin
						s_d.rxBuf[s_q.count] = rx.data;
						s_d.count = s_q.count + 6'h01;
					end
					else
						s_d.over = 1'b1;
					if (rx.last)
					begin
						s_d.crcOk = rx.crcOk;
						s_d.phase = mpio_pkg::phFrame;
					end
				end
			end
			mpio_pkg::phFrame:
			begin
				s_d.pos = 6'h00;
				s_d.commit = 1'b0;
				s_d.cause = frameCause;
				if (frameDrop)
				begin
					s_d.phase = mpio_pkg::phIdle;
					s_d.count = 6'h00;
					s_d.over = 1'b0;
				end
				else if (frameCause != mpio_pkg::CAUSE_NONE)
					s_d.phase = mpio_pkg::phReply;
				else
					s_d.phase = mpio_pkg::phCheck;
			end
			mpio_pkg::phCheck:
			begin
				if ({10'h000, s_q.pos} >= qtyEff)
				begin
					// Nothing is stored until every register has passed
					if (s_q.commit || !isWrite)
						s_d.phase = mpio_pkg::phReply;
					else
					begin
						s_d.commit = 1'b1;
						s_d.pos = 6'h00;
					end
				end
				else
				begin
					if (!s_q.commit && isWrite && isPass && qtyEff == 16'h0001
						&& regCause == mpio_pkg::CAUSE_NONE)
					begin
						s_d.unlocked = 1'b1;
						s_d.unlockMs = 16'h0000;
						s_d.wrongCnt = 3'h0;
					end
					else if (regCause == mpio_pkg::CAUSE_WRONG_PASSWORD
						|| regCause == mpio_pkg::CAUSE_WRONG_FIVE)
					begin
						if (!s_q.commit && s_q.wrongCnt < mpio_pkg::WRONG_LIMIT)
							s_d.wrongCnt = s_q.wrongCnt + 3'h1;
					end
					if (!s_q.commit && regCause != mpio_pkg::CAUSE_NONE)
					begin
						s_d.cause = regCause;
						s_d.phase = mpio_pkg::phReply;
					end
					else
					begin
						s_d.pos = s_q.pos + step;
						if (!isWrite)
						begin
							{s_d.txBuf[txPos], s_d.txBuf[txPos + 6'h01]} =
								isPass ? 16'h0000 : rd32[15:0];
							if (wideLow)
								{s_d.txBuf[txPos + 6'h02], s_d.txBuf[txPos + 6'h03]} =
									rd32[31:16];
						end
						else if (s_q.commit && isOwn)
						begin
							selWrite = regAddr == mpio_pkg::ADDR_SEL_A;
							if (regAddr != mpio_pkg::ADDR_SEL_D)
								s_d.sel[regAddr[1:0] - 2'h3] = w0;
							if (selWrite && w0[mpio_pkg::BIT_SERVO_ON])
								s_d.refreshMs = 16'h0000;
							if (selWrite)
							begin
								s_d.faultReset = w0[mpio_pkg::BIT_FAULT_RESET]
									& commInputEnableMask[mpio_pkg::BIT_FAULT_RESET];
								s_d.posClear = w0[mpio_pkg::BIT_POSITION_ERROR_CLEAR]
									& commInputEnableMask[mpio_pkg::BIT_POSITION_ERROR_CLEAR];
							end
						end
						else if (s_q.commit && isExt)
						begin
							s_d.pw.strobe = 1'b1;
							s_d.pw.address = regAddr;
							s_d.pw.data = value32;
							s_d.pw.wide = wideLow;
							s_d.pw.nonVolatile = nonVolatile;
						end
					end
				end
			end
			mpio_pkg::phReply:
			begin
				s_d.txIdx = 6'h00;
				s_d.txBuf[0] = s_q.rxBuf[0];
				s_d.phase = mpio_pkg::phSend;
				if (s_q.cause != mpio_pkg::CAUSE_NONE)
				begin
					s_d.txBuf[1] = func | mpio_pkg::EXC_FLAG;
					s_d.txBuf[2] = s_q.cause;
					s_d.txLen = 6'h03;
				end
				else if (!isWrite)
				begin
					s_d.txBuf[1] = func;
					s_d.txBuf[2] = {qtyField[6:0], 1'b0};
					s_d.txLen = {qtyField[4:0], 1'b0} + 6'h03;
				end
				else
				begin
					s_d.txBuf[5:1] = s_q.rxBuf[5:1];
					s_d.txLen = 6'h06;
				end
				if (s_q.rxBuf[0] == 8'h00)
				begin
					s_d.phase = mpio_pkg::phIdle;
					s_d.count = 6'h00;
				end
			end
			mpio_pkg::phSend:
			begin
				if (txReady)
				begin
					s_d.txIdx = s_q.txIdx + 6'h01;
					if (txLast)
					begin
						s_d.phase = mpio_pkg::phIdle;
						s_d.count = 6'h00;
						s_d.over = 1'b0;
					end
				end
			end
			default:
				s_d.phase = mpio_pkg::phIdle;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	exception_frame_a: assert property (@(posedge clock) disable iff (rst)
		txValid && s_q.cause != mpio_pkg::CAUSE_NONE |-> s_q.txLen == 6'h03
		&& s_q.txBuf[1] == (s_q.rxBuf[1] | mpio_pkg::EXC_FLAG))
		else $error("exception frame malformed");
	zero_qty_a: assert property (@(posedge clock) disable iff (rst)
		s_q.phase == mpio_pkg::phFrame && !frameDrop && s_q.crcOk
		&& func == mpio_pkg::FN_READ && s_q.count == 6'h06 && qtyField == 16'h0000
		|=> s_q.phase == mpio_pkg::phReply && s_q.cause == mpio_pkg::CAUSE_QTY_ZERO)
		else $error("zero quantity not refused");
	half_access_a: assert property (@(posedge clock) disable iff (rst)
		s_q.phase == mpio_pkg::phCheck && !s_q.commit && isEncHigh
		&& {10'h000, s_q.pos} < qtyEff |=> s_q.cause == mpio_pkg::CAUSE_HALF)
		else $error("half access not refused");
	no_write_refused_a: assert property (@(posedge clock) disable iff (rst)
		s_q.phase == mpio_pkg::phCheck && regCause == mpio_pkg::CAUSE_RANGE
		&& !s_q.commit |=> !s_q.pw.strobe [*2])
		else $error("write issued after range refusal");
	wrong_five_a: assert property (@(posedge clock) disable iff (rst)
		s_q.phase == mpio_pkg::phCheck && !s_q.commit && isWrite && isPass
		&& qtyEff == 16'h0001 && isExt == 1'b0 && w0 != userPassword
		&& s_q.wrongCnt >= 3'h4 |=> s_q.cause == mpio_pkg::CAUSE_WRONG_FIVE)
		else $error("fifth wrong password not flagged");
	reserved_in_a: assert property (@(posedge clock) disable iff (rst)
		!commInputFunctions[0] && commInputFunctions[63:35] == 29'h00000000)
		else $error("reserved input function driven");
	servo_drop_a: assert property (@(posedge clock) disable iff (rst)
		refreshExpire && !selWrite |=> !s_q.sel[0][mpio_pkg::BIT_SERVO_ON])
		else $error("servo-on kept after refresh timeout");
	single_pulse_a: assert property (@(posedge clock) disable iff (rst)
		faultResetPulse |=> !faultResetPulse)
		else $error("fault reset pulse too long");
	conflict_fault_a: assert property (@(posedge clock) disable iff (rst)
		|(commInputFunctions & physicalInputAssigned) |=> inputConflictFault)
		else $error("input conflict not raised");
	speed_bit_a: assert property (@(posedge clock) disable iff (rst)
		outA[mpio_pkg::BIT_SPEED_COINCIDENCE_FLAG] == (outputFunctionActive[6]
		&& commOutputEnableMask[6] && !physicalOutputAssigned[6]))
		else $error("speed coincidence bit wrong");
	echo_len_a: assert property (@(posedge clock) disable iff (rst)
		txValid && s_q.cause == mpio_pkg::CAUSE_NONE && s_q.rxBuf[1] != 8'h03
		|-> s_q.txLen == 6'h06)
		else $error("write echo length wrong");
endmodule // modbus_param_io_access

/* design/mpio_pkg.sv */
// Constants, codes and carrier types for the serial parameter/IO handler.
// Assumes a framer that strips the CRC and flags its result per frame.
package mpio_pkg;
	localparam int FRAME_MAX = 34;
	localparam int READ_MAX = 15;
	localparam int WRITE_MAX = 13;
	localparam logic [7:0] FN_READ = 8'h03;
	localparam logic [7:0] FN_WRITE_ONE = 8'h06;
	localparam logic [7:0] FN_WRITE_MULTI = 8'h10;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] CAUSE_NONE = 8'h00;
	localparam logic [7:0] CAUSE_BAD_CMD = 8'h01;
	localparam logic [7:0] CAUSE_BAD_PARAM = 8'h03;
	localparam logic [7:0] CAUSE_CRC = 8'h04;
	localparam logic [7:0] CAUSE_GROUP = 8'h16;
	localparam logic [7:0] CAUSE_QTY_ZERO = 8'h17;
	localparam logic [7:0] CAUSE_HALF = 8'h18;
	localparam logic [7:0] CAUSE_RANGE = 8'h19;
	localparam logic [7:0] CAUSE_LOCKED = 8'h20;
	localparam logic [7:0] CAUSE_NOT_EDITABLE = 8'h22;
	localparam logic [7:0] CAUSE_PASSWORD_MIX = 8'h24;
	localparam logic [7:0] CAUSE_WRONG_PASSWORD = 8'h25;
	localparam logic [7:0] CAUSE_WRONG_FIVE = 8'h26;
	localparam logic [2:0] WRONG_LIMIT = 3'h5;
	localparam logic [15:0] ADDR_SEL_A = 16'h3607;
	localparam logic [15:0] ADDR_SEL_B = 16'h3608;
	localparam logic [15:0] ADDR_SEL_C = 16'h3609;
	localparam logic [15:0] ADDR_SEL_D = 16'h360A;
	localparam logic [15:0] ADDR_OUT_A = 16'h3688;
	localparam logic [15:0] ADDR_OUT_B = 16'h3609;
	localparam logic [15:0] ADDR_TURNS = 16'h1520;
	localparam logic [15:0] ADDR_SINGLE = 16'h1522;
	localparam logic [15:0] NV_OFFSET = 16'hE000;
	localparam int BIT_SERVO_ON = 1;
	localparam int BIT_FAULT_RESET = 2;
	localparam int BIT_POSITION_ERROR_CLEAR = 5;
	localparam int BIT_SPEED_COINCIDENCE_FLAG = 6;
	localparam logic [15:0] SEL_A_MASK = 16'hFFFE;
	localparam logic [15:0] SEL_C_MASK = 16'h0007;
	localparam logic [15:0] OUT_A_MASK = 16'hFFFE;
	localparam int CLOCK_PERIOD_NS = 8;
	localparam int TICK_TIME_NS = 1000000;
	localparam int TICK_CYCLES_DEFAULT = TICK_TIME_NS / CLOCK_PERIOD_NS;
	localparam logic [15:0] UNLOCK_MS_DEFAULT = 16'hEA60;

	typedef enum logic [2:0] {phIdle, phFrame, phCheck, phReply, phSend} phase_t;

	typedef struct packed {
		logic valid;
		logic last;
		logic crcOk;
		logic [7:0] data;
	} rx_byte_t;

	typedef struct packed {
		logic strobe;
		logic [15:0] address;
		logic [31:0] data;
		logic wide;
		logic nonVolatile;
	} param_write_t;

	typedef struct packed {
		phase_t phase;
		logic [FRAME_MAX-1:0][7:0] rxBuf;
		logic [5:0] count;
		logic over;
		logic crcOk;
		logic [5:0] pos;
		logic commit;
		logic [7:0] cause;
		logic [FRAME_MAX-1:0][7:0] txBuf;
		logic [5:0] txLen;
		logic [5:0] txIdx;
		logic [2:0][15:0] sel;
		logic [31:0] prescale;
		logic [15:0] refreshMs;
		logic unlocked;
		logic [15:0] unlockMs;
		logic [2:0] wrongCnt;
		logic faultReset;
		logic posClear;
		logic conflict;
		param_write_t pw;
	} state_t;
endpackage

/* dv/bus_master.sv */
// Bus master model: sends request frames, gathers reply bytes.
// Assumes the handler's clock; the framer owns the CRC bytes.
`timescale 1ns/100ps
module bus_master (
	input wire logic clock,
	input wire logic slow,
	output mpio_pkg::rx_byte_t rx,
	input wire logic txValid,
	input wire logic [7:0] txByte,
	input wire logic txLast,
	output logic txReady
);
	logic [7:0] reply[$];
	logic got;
	initial
	begin
		rx = '0;
		txReady = 1'b1;
		got = 1'b0;
	end
	// Drops txReady every other cycle in slow mode
	always @(posedge clock)
	begin
		txReady <= slow ? ~txReady : 1'b1;
		if (txValid && txReady)
		begin
			reply.push_back(txByte);
			if (txLast)
				got <= 1'b1;
		end
	end
	task automatic send(input logic [7:0] f[$], input logic ok);
		reply.delete();
		got <= 1'b0;
		foreach (f[i])
		begin
			@(posedge clock);
			rx <= '{1'b1, i == f.size() - 1, ok, f[i]};
		end
		@(posedge clock);
		// Idle line shows the inverse of the last byte
		rx <= '{1'b0, 1'b0, 1'b0, ~f[f.size() - 1]};
	endtask
endmodule // bus_master

/* dv/testbench.sv */
// Self-checking bench for the serial parameter and IO handler.
// Assumes bus_master as far side; parameter attributes modelled here.
`timescale 1ns/100ps
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin \
	errCount++; $display("BAD %s exp %h saw %h", n, e, s); end end
module testbench;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic slow = 1'b0;
	mpio_pkg::rx_byte_t rx;
	logic txValid;
	logic txLast;
	logic txReady;
	logic [7:0] txByte;
	logic [15:0] lookupAddr;
	mpio_pkg::param_write_t paramWrite;
	mpio_pkg::param_write_t lastWrite = '0;
	logic [63:0] inMask = 64'hFFFFFFFFFFFF7FFF;
	logic [63:0] physIn = 64'h0;
	logic [63:0] functions;
	logic [31:0] outAct = 32'h00020041;
	logic [31:0] outMask = 32'h00020040;
	logic [31:0] physOut = 32'h0;
	logic [31:0] turns = 32'h00010003;
	logic [31:0] single = 32'h00013607;
	logic locked = 1'b0;
	logic [15:0] password = 16'h1234;
	logic resetPulse;
	logic clearPulse;
	logic conflict;
	int errCount = 0;
	int comparisons = 0;
	int cycles = 0;
	int rPulses = 0;
	int cPulses = 0;
	always #4 clock = ~clock;
	bus_master m (.clock(clock), .slow(slow), .rx(rx), .txValid(txValid),
		.txByte(txByte), .txLast(txLast), .txReady(txReady));
	modbus_param_io_access #(.TICK_CYCLES(10), .UNLOCK_MS(16'h0003)) uut (
		.clock(clock), .rst(rst), .stationAddress(8'h01), .rx(rx),
		.txValid(txValid), .txByte(txByte), .txLast(txLast),
		.txReady(txReady), .lookupAddr(lookupAddr),
		.attrExists(lookupAddr != 16'h0900),
		.attrWide(lookupAddr == 16'h0810),
		.attrUpper(lookupAddr == 16'h0811),
		.attrEditable(lookupAddr != 16'h0802), .attrMin(32'h0),
		.attrMax({16'h0, lookupAddr}),
		.paramReadData({lookupAddr, lookupAddr}), .paramWrite(paramWrite),
		.protectionActive(locked), .userPassword(password),
		.commInputEnableMask(inMask), .physicalInputAssigned(physIn),
		.commRefreshTimeoutSetting(16'h0003), .commInputFunctions(functions),
		.faultResetPulse(resetPulse), .positionErrorClearFunction(clearPulse),
		.inputConflictFault(conflict), .outputFunctionActive(outAct),
		.commOutputEnableMask(outMask), .physicalOutputAssigned(physOut),
		.encoderTurns(turns), .encoderSingleTurn(single));
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (resetPulse)
			rPulses <= rPulses + 1;
		if (clearPulse)
			cPulses <= cPulses + 1;
		if (paramWrite.strobe)
			lastWrite <= paramWrite;
		if (cycles == 20000)
		begin
			errCount++;
			giveVerdict();
		end
	end
	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", comparisons, errCount);
		if (errCount == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic checkReply(input logic [7:0] e[$]);
		int n;
		n = 0;
		while (!m.got && n < 400)
		begin
			@(posedge clock);
			n++;
		end
		#1;
		`CHK("reply length", e.size(), m.reply.size())
		foreach (e[i])
			`CHK("reply byte", e[i], m.reply[i])
	endtask
	task automatic echo(input logic [7:0] f[$]);
		m.send(f, 1'b1);
		checkReply(f);
	endtask
	task automatic reject(input logic [7:0] f[$], input logic ok,
		input logic [7:0] cause);
		m.send(f, ok);
		checkReply('{8'h01, f[1] | 8'h80, cause});
	endtask
	task automatic testSelect();
		echo('{8'h01, 8'h06, 8'h36, 8'h07, 8'h80, 8'h03});
		`CHK("select a", 16'h0002, functions[15:0])
		m.send('{8'h01, 8'h10, 8'h36, 8'h08, 8'h00, 8'h01, 8'h02,
			8'h80, 8'h01}, 1'b1);
		checkReply('{8'h01, 8'h10, 8'h36, 8'h08, 8'h00, 8'h01});
		`CHK("select b", 16'h8001, functions[31:16])
		echo('{8'h01, 8'h06, 8'h36, 8'h09, 8'hFF, 8'hFF});
		`CHK("select c", 32'h7, functions[63:32])
		$display("test select done");
	endtask
	task automatic testPulse();
		int r;
		int c;
		r = rPulses;
		c = cPulses;
		echo('{8'h01, 8'h06, 8'h36, 8'h07, 8'h00, 8'h24});
		repeat (3) @(posedge clock);
		`CHK("fault reset pulses", r + 1, rPulses)
		`CHK("error clear pulses", c + 1, cPulses)
		$display("test pulse done");
	endtask
	task automatic testServo();
		echo('{8'h01, 8'h06, 8'h36, 8'h07, 8'h00, 8'h02});
		`CHK("servo on", 1'b1, functions[1])
		@(posedge clock);
		physIn <= 64'h2;
		repeat (3) @(posedge clock);
		`CHK("conflict", 1'b1, conflict)
		physIn <= 64'h0;
		echo('{8'h01, 8'h06, 8'h36, 8'h07, 8'h00, 8'h00});
		`CHK("servo off by zero", 1'b0, functions[1])
		echo('{8'h01, 8'h06, 8'h36, 8'h07, 8'h00, 8'h02});
		repeat (80) @(posedge clock);
		`CHK("servo off by timeout", 1'b0, functions[1])
		$display("test servo done");
	endtask
	task automatic testRead();
		@(posedge clock);
		slow <= 1'b1;
		m.send('{8'h01, 8'h03, 8'h36, 8'h88, 8'h00, 8'h01}, 1'b1);
		checkReply('{8'h01, 8'h03, 8'h02, 8'h00, 8'h40});
		m.send('{8'h01, 8'h03, 8'h36, 8'h09, 8'h00, 8'h01}, 1'b1);
		checkReply('{8'h01, 8'h03, 8'h02, 8'h00, 8'h02});
		@(posedge clock);
		physOut <= 32'h40;
		m.send('{8'h01, 8'h03, 8'h36, 8'h88, 8'h00, 8'h01}, 1'b1);
		checkReply('{8'h01, 8'h03, 8'h02, 8'h00, 8'h00});
		m.send('{8'h01, 8'h03, 8'h15, 8'h20, 8'h00, 8'h02}, 1'b1);
		checkReply('{8'h01, 8'h03, 8'h04, 8'h00, 8'h03, 8'h00, 8'h01});
		m.send('{8'h01, 8'h03, 8'h15, 8'h22, 8'h00, 8'h02}, 1'b1);
		checkReply('{8'h01, 8'h03, 8'h04, 8'h36, 8'h07, 8'h00, 8'h01});
		@(posedge clock);
		slow <= 1'b0;
		$display("test read done");
	endtask
	task automatic testErrors();
		reject('{8'h01, 8'h06, 8'h08, 8'h01, 8'h20, 8'h00}, 1, 8'h19);
		reject('{8'h01, 8'h06, 8'h08, 8'h02, 8'h00, 8'h01}, 1, 8'h22);
		reject('{8'h01, 8'h06, 8'h08, 8'h10, 8'h00, 8'h01}, 1, 8'h18);
		reject('{8'h01, 8'h06, 8'h09, 8'h00, 8'h00, 8'h01}, 1, 8'h03);
		reject('{8'h01, 8'h06, 8'h20, 8'h01, 8'h00, 8'h01}, 1, 8'h16);
		reject('{8'h01, 8'h06, 8'h08, 8'h01, 8'h00, 8'h01}, 0, 8'h04);
		reject('{8'h01, 8'h07, 8'h08, 8'h01, 8'h00, 8'h01}, 1, 8'h01);
		reject('{8'h01, 8'h10, 8'h08, 8'h01, 8'h00, 8'h00, 8'h00},
			1, 8'h17);
		reject('{8'h01, 8'h10, 8'h08, 8'h01, 8'h00, 8'h01, 8'h04,
			8'h00, 8'h01}, 1, 8'h03);
		reject('{8'h01, 8'h03, 8'h08, 8'h01, 8'h00, 8'h00}, 1, 8'h17);
		reject('{8'h01, 8'h03, 8'h15, 8'h21, 8'h00, 8'h01}, 1, 8'h18);
		echo('{8'h01, 8'h06, 8'hE8, 8'h01, 8'h00, 8'h05});
		`CHK("stored address", 16'h0801, lastWrite.address)
		`CHK("non volatile", 1'b1, lastWrite.nonVolatile)
		`CHK("stored data", 32'h5, lastWrite.data)
		$display("test errors done");
	endtask
	task automatic testPassword();
		@(posedge clock);
		locked <= 1'b1;
		reject('{8'h01, 8'h06, 8'h08, 8'h01, 8'h00, 8'h05}, 1, 8'h20);
		repeat (4)
			reject('{8'h01, 8'h06, 8'h00, 8'h00, 8'h00, 8'h01}, 1, 8'h25);
		reject('{8'h01, 8'h06, 8'h00, 8'h00, 8'h00, 8'h01}, 1, 8'h26);
		reject('{8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h02, 8'h04,
			8'h12, 8'h34, 8'h00, 8'h05}, 1, 8'h24);
		echo('{8'h01, 8'h06, 8'h00, 8'h00, 8'h12, 8'h34});
		echo('{8'h01, 8'h06, 8'h08, 8'h01, 8'h00, 8'h05});
		// Unlock lifetime runs out
		repeat (50) @(posedge clock);
		reject('{8'h01, 8'h06, 8'h08, 8'h01, 8'h00, 8'h05}, 1, 8'h20);
		@(posedge clock);
		locked <= 1'b0;
		$display("test password done");
	endtask
	initial
	begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		testSelect();
		testPulse();
		testServo();
		testRead();
		testErrors();
		testPassword();
		giveVerdict();
	end
endmodule // testbench
